// *** core/mcdr_pkg.sv ***
/*
  constants, types and address map for the memory controller decode and remap block.
  assumes a single 100 mhz clock domain and a 32-bit core address bus.
*/
// How it works
// [RQ1] lowest four megabytes go to internal memory
// [RQ2] highest four megabytes go to peripherals
// [RQ3] middle space goes to external bus interface
// [RQ4] little-endian lanes only, no big-endian mode
// [RQ5] 8-kbyte 32-bit sram at zero after remap
// [RQ6] sram byte, half, word access in one cycle
// [RQ7] strap sampled in last cycles before reset release
// [RQ8] strap one boots 8-bit, zero boots 16-bit
// [RQ9] after reset address zero fetches boot memory
// [RQ10] remap command bit write swaps in internal ram
// [RQ11] chip selects one to seven only after remap
// [RQ12] remap cleared only by reset, not software
// [RQ13] undefined external address raises core abort
// [RQ14] internal memory and peripherals never abort
// [RQ15] eight 16-mbyte external banks, all access sizes
// [RQ16] peripheral byte and half accesses become words
// [RQ17] peripheral windows 16-kbyte, interrupt unit 4-kbyte
// [RQ18] reset asserts asynchronously, releases on clock
// [RQ19] any reset clears remap state; internal reset clears it only while ce is high
package mcdr_pkg;
  localparam logic [31:0] MCDR_INT_TOP     = 32'h003f_ffff; // end of internal space
  localparam logic [31:0] MCDR_EXT_LO      = 32'h0040_0000; // first external address
  localparam logic [31:0] MCDR_EXT_HI      = 32'hffc0_0000; // first peripheral address
  localparam int          MCDR_SRAM_BYTES  = 8192;          // internal bank size
  localparam int          MCDR_SRAM_AW     = 11;            // word index width
  localparam int          MCDR_BANK_SHIFT  = 24;            // 16-mbyte banks
  localparam int          MCDR_NBANKS      = 8;             // chip selects
  localparam int          MCDR_PER_SHIFT   = 14;            // 16-kbyte windows
  localparam logic [7:0]  MCDR_ICU_SLOT    = 8'hff;         // last window holds interrupt unit
  localparam logic [13:0] MCDR_ICU_LIMIT   = 14'h0fff;      // interrupt unit is 4-kbyte
  localparam int          MCDR_STRAP_CYC   = 10;            // strap sample cycles
  localparam logic [1:0]  MCDR_SZ_BYTE     = 2'h0;          // access size codes
  localparam logic [1:0]  MCDR_SZ_HALF     = 2'h1;
  localparam logic [1:0]  MCDR_SZ_WORD     = 2'h2;
  localparam logic [1:0]  MCDR_ADDR_LOW    = 2'h0;          // masked low address bits

  typedef enum logic [1:0] {
    MCDR_RGN_INT = 2'b00,  // internal memory
    MCDR_RGN_EXT = 2'b01,  // external bus interface
    MCDR_RGN_PER = 2'b11   // on-chip peripherals
  } mcdr_region_t;

  // one core request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mcdr_req_t;

  // one forwarded access toward a target
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } mcdr_fwd_t;
endpackage : mcdr_pkg

// *** core/mcdr_top.sv ***
/*
  memory controller decode, remap, boot strap, abort and internal sram.
  assumes the core presents one request per cycle and the external and
  peripheral targets answer combinationally, with no ready input to stall on.
*/
`timescale 1ns/10ps
`default_nettype none
module mcdr_top
  import mcdr_pkg::*;
#(
  parameter int STRAP_CYC = MCDR_STRAP_CYC  // strap filter depth
) (
  input  wire logic      clk,
  input  wire logic      rstn,               // external_reset_n pin
  input  wire logic      int_reset,          // internal reset pulse, same clock
  input  wire logic      ce,
  input  wire logic      boot_width_strap,   // port_b_line_strap_shared
  input  wire mcdr_req_t core_req,
  input  wire logic      remap_command_bit,  // write strobe of remap_control_register
  input  wire logic [7:0] ebi_defined,       // bank has a configured device
  output logic [31:0]    core_rdata,
  output logic           core_abort,
  output mcdr_fwd_t      ebi_fwd,
  output logic [7:0]     chip_select,
  output logic           boot_is_8bit,
  output logic           remapped,
  input  wire logic [31:0] ebi_rdata,
  output mcdr_fwd_t      per_fwd,
  output logic           per_icu_sel,
  input  wire logic [31:0] per_rdata
);
  // reset release synchroniser
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0; // RQ18
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic srst_n = rst_s2_r; // synchronised reset, low active

  // strap synchroniser, first stage read only by second
  // no reset here: the strap must be seen while the pin reset is still low
  logic strap_s1_r, strap_s2_r;
  always_ff @(posedge clk) begin
    strap_s1_r <= boot_width_strap;
    strap_s2_r <= strap_s1_r;
  end

  // strap history; shifts while pin reset is held so the last cycles are seen
  logic [STRAP_CYC-1:0] strap_hist_r;
  logic                 boot8_r;
  logic                 sampled_r;
  wire  logic           strap_all1 = &strap_hist_r;
  wire  logic           strap_all0 = ~|strap_hist_r;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      sampled_r <= 1'b0;
    end else if (ce) begin
      sampled_r <= 1'b1;
    end
  end
  // history runs on the raw clock only until the sample is latched
  always_ff @(posedge clk) begin
    if (!sampled_r) begin
      strap_hist_r <= {strap_hist_r[STRAP_CYC-2:0], strap_s2_r}; // RQ7
    end
  end
  // latch at release; internal reset does not resample; unstable strap keeps last bit
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      boot8_r <= 1'b0;
    end else if (ce && !sampled_r) begin
      boot8_r <= strap_all1 ? 1'b1 : (strap_all0 ? 1'b0 : strap_hist_r[0]); // RQ8
    end
  end
  assign boot_is_8bit = boot8_r; // RQ8

  // remap state: set by command, cleared only by a reset
  logic remap_r;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      remap_r <= 1'b0; // RQ19
    end else if (ce) begin
      if (int_reset) begin
        remap_r <= 1'b0; // RQ12 RQ19
      end else if (remap_command_bit) begin
        remap_r <= 1'b1; // RQ10
      end
    end
  end
  assign remapped = remap_r;

  // region decode
  wire logic a  = core_req.valid;
  wire logic [31:0] ad = core_req.addr;
  wire logic in_int = (ad <= MCDR_INT_TOP);                      // RQ1
  wire logic in_per = (ad >= MCDR_EXT_HI);                       // RQ2
  wire logic in_ext = (ad >= MCDR_EXT_LO) && (ad < MCDR_EXT_HI); // RQ3
  // before remap the low space is boot memory on chip select zero
  wire logic boot_sel  = in_int && !remap_r;                     // RQ9
  wire logic sram_sel  = in_int && remap_r;                      // RQ5
  wire logic [2:0] bank = ad[MCDR_BANK_SHIFT+2:MCDR_BANK_SHIFT]; // RQ15
  wire logic ext_bank_ok = remap_r && ebi_defined[bank];          // RQ11
  wire logic ext_sel = in_ext && ext_bank_ok;
  wire logic ext_bad = a && in_ext && !ext_bank_ok;               // RQ13

  // little-endian byte enables, used for sram and external bus
  function automatic logic [3:0] mcdr_be(input logic [1:0] sz, input logic [1:0] lo);
    logic [3:0] m;
    m = 4'h0;
    unique case (sz)
      MCDR_SZ_BYTE: m = 4'h1 << lo;          // RQ4
      MCDR_SZ_HALF: m = lo[1] ? 4'hc : 4'h3; // RQ4
      default:      m = 4'hf;
    endcase
    return m;
  endfunction : mcdr_be
  wire logic [3:0] be = mcdr_be(core_req.size, ad[1:0]);

  // external forward and chip selects
  always_comb begin
    ebi_fwd       = '0;
    ebi_fwd.valid = a && (ext_sel || boot_sel); // RQ15
    ebi_fwd.write = core_req.write;
    ebi_fwd.size  = core_req.size;
    ebi_fwd.addr  = ad;
    ebi_fwd.wdata = core_req.wdata;
    ebi_fwd.be    = be;
    chip_select   = 8'h00;
    if (a && boot_sel) chip_select[0] = 1'b1; // RQ9
    else if (a && ext_sel) chip_select[bank] = 1'b1;
  end

  // peripheral forward: low bits masked, always a word
  wire logic [7:0] per_slot = ad[MCDR_PER_SHIFT+7:MCDR_PER_SHIFT]; // RQ17
  always_comb begin
    per_fwd       = '0;
    per_fwd.valid = a && in_per;
    per_fwd.write = core_req.write;
    per_fwd.size  = MCDR_SZ_WORD;                 // RQ16
    per_fwd.addr  = {ad[31:2], MCDR_ADDR_LOW};    // RQ16
    per_fwd.wdata = core_req.wdata;
    per_fwd.be    = 4'hf;                         // RQ16
  end
  // interrupt unit decodes only its 4-kbyte part of the last window
  assign per_icu_sel = a && in_per && (per_slot == MCDR_ICU_SLOT) &&
                       (ad[MCDR_PER_SHIFT-1:0] <= MCDR_ICU_LIMIT); // RQ17

  // internal sram, word array with lane enables, one cycle
  logic [31:0] sram_mem [MCDR_SRAM_BYTES/4];
  wire  logic [MCDR_SRAM_AW-1:0] widx = ad[MCDR_SRAM_AW+1:2]; // wraps every 8 kbyte within the 4-mbyte region
  always_ff @(posedge clk) begin
    if (ce && a && sram_sel && core_req.write) begin
      for (int i = 0; i < 4; i++) begin
        if (be[i]) sram_mem[widx][8*i +: 8] <= core_req.wdata[8*i +: 8]; // RQ6
      end
    end
  end

  // registered read data and abort
  logic [31:0] rdata_r;
  logic        abort_r;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      rdata_r <= 32'h0000_0000;
      abort_r <= 1'b0;
    end else if (ce) begin
      abort_r <= ext_bad; // RQ13 RQ14
      if (a && sram_sel) rdata_r <= sram_mem[widx]; // RQ6
      else if (a && in_per) rdata_r <= per_rdata;
      else if (a && (ext_sel || boot_sel)) rdata_r <= ebi_rdata;
    end
  end
  assign core_rdata = rdata_r;
  assign core_abort = abort_r;

  // abort only for the external space
  sram_no_abort_a: assert property ( // RQ14
    @(posedge clk) disable iff (!srst_n)
    ce && a && !in_ext |=> !core_abort)
    else $error("abort on internal access");
  // external access before remap is refused
  ext_abort_a: assert property ( // RQ13
    @(posedge clk) disable iff (!srst_n)
    ce && a && in_ext && !remap_r |=> core_abort)
    else $error("missing abort");
  // defined external bank never aborts after remap
  ext_ok_a: assert property ( // RQ13
    @(posedge clk) disable iff (!srst_n)
    ce && a && ext_sel |=> !core_abort)
    else $error("abort on defined bank");
  // boot memory sits on chip select zero
  boot_cs0_a: assert property ( // RQ9
    @(posedge clk) disable iff (!srst_n)
    a && in_int && !remap_r |-> chip_select == 8'h01)
    else $error("boot not on cs0");
  // boot access goes out on the external bus
  boot_fwd_a: assert property ( // RQ9
    @(posedge clk) disable iff (!srst_n)
    a && boot_sel |-> ebi_fwd.valid)
    else $error("boot access not forwarded");
  // remap survives everything but a reset
  remap_sticky_a: assert property ( // RQ12
    @(posedge clk) disable iff (!srst_n)
    remap_r && !int_reset |=> remap_r)
    else $error("remap lost");
  // internal reset clears the remap state
  remap_clear_a: assert property ( // RQ19
    @(posedge clk) disable iff (!srst_n)
    ce && int_reset |=> !remapped)
    else $error("remap kept over reset");
  // command sets remap one cycle later
  remap_set_a: assert property ( // RQ10
    @(posedge clk) disable iff (!srst_n)
    ce && remap_command_bit && !int_reset |=> remapped)
    else $error("remap not set");
  // latched boot width does not move after sampling
  strap_hold_a: assert property ( // RQ8
    @(posedge clk) disable iff (!srst_n)
    sampled_r |=> $stable(boot_is_8bit))
    else $error("boot width changed");
  // peripheral access is a full aligned word
  per_word_a: assert property ( // RQ16
    @(posedge clk) disable iff (!srst_n)
    per_fwd.valid |-> per_fwd.addr[1:0] == 2'h0 && per_fwd.be == 4'hf)
    else $error("peripheral not word");
  // peripheral access size is forced to word
  per_size_a: assert property ( // RQ16
    @(posedge clk) disable iff (!srst_n)
    per_fwd.valid |-> per_fwd.size == MCDR_SZ_WORD)
    else $error("peripheral size not word");
  // top space goes only to peripherals
  per_route_a: assert property ( // RQ2
    @(posedge clk) disable iff (!srst_n)
    a && ad >= MCDR_EXT_HI |-> per_fwd.valid && !ebi_fwd.valid)
    else $error("peripheral misrouted");
  // no chip select for a peripheral access
  per_no_cs_a: assert property ( // RQ2
    @(posedge clk) disable iff (!srst_n)
    a && in_per |-> chip_select == 8'h00)
    else $error("chip select on peripheral");
  // peripheral read data returns next cycle
  per_rdata_a: assert property ( // RQ2
    @(posedge clk) disable iff (!srst_n)
    ce && a && in_per |=> core_rdata == $past(per_rdata))
    else $error("peripheral read data lost");
  // interrupt unit select only inside peripheral space
  icu_in_per_a: assert property ( // RQ17
    @(posedge clk) disable iff (!srst_n)
    per_icu_sel |-> per_fwd.valid)
    else $error("interrupt unit outside peripherals");
  // low 4 kbyte of the last window hit the interrupt unit
  icu_window_a: assert property ( // RQ17
    @(posedge clk) disable iff (!srst_n)
    a && in_per && per_slot == MCDR_ICU_SLOT &&
    ad[MCDR_PER_SHIFT-1:MCDR_PER_SHIFT-2] == 2'h0 |-> per_icu_sel)
    else $error("interrupt unit window missed");
  // chip selects 1 to 7 only after remap
  ext_gate_a: assert property ( // RQ11
    @(posedge clk) disable iff (!srst_n)
    !remap_r |-> chip_select[7:1] == 7'h00)
    else $error("cs1-7 before remap");
  // defined bank gets its own chip select
  ext_cs_a: assert property ( // RQ3
    @(posedge clk) disable iff (!srst_n)
    a && in_ext && remap_r && ebi_defined[bank] |-> chip_select == (8'h01 << bank))
    else $error("wrong chip select");
  // at most one chip select at a time
  cs_onehot_a: assert property ( // RQ15
    @(posedge clk) disable iff (!srst_n)
    $onehot0(chip_select))
    else $error("several chip selects");
  // external forward carries the core request unchanged
  ext_fwd_a: assert property ( // RQ15
    @(posedge clk) disable iff (!srst_n)
    a && ext_sel |-> ebi_fwd.valid && ebi_fwd.size == core_req.size && ebi_fwd.addr == core_req.addr)
    else $error("external forward corrupted");
  // external read data returns next cycle
  ext_rdata_a: assert property ( // RQ3
    @(posedge clk) disable iff (!srst_n)
    ce && a && ext_sel |=> core_rdata == $past(ebi_rdata))
    else $error("external read data lost");
  // byte access uses the one lane its address names
  byte_lane_a: assert property ( // RQ4
    @(posedge clk) disable iff (!srst_n)
    ebi_fwd.valid && core_req.size == MCDR_SZ_BYTE |-> $onehot(ebi_fwd.be) && ebi_fwd.be[ad[1:0]])
    else $error("byte lane wrong");
  // upper half word uses the two high lanes
  half_lane_a: assert property ( // RQ4
    @(posedge clk) disable iff (!srst_n)
    ebi_fwd.valid && core_req.size == MCDR_SZ_HALF && ad[1] |-> ebi_fwd.be == 4'hc)
    else $error("half lane wrong");
  // word access uses all four lanes
  word_lane_a: assert property ( // RQ4
    @(posedge clk) disable iff (!srst_n)
    ebi_fwd.valid && core_req.size == MCDR_SZ_WORD |-> ebi_fwd.be == 4'hf)
    else $error("word lanes wrong");
  // internal access never leaves the chip after remap
  sram_no_cs_a: assert property ( // RQ5
    @(posedge clk) disable iff (!srst_n)
    a && sram_sel |-> chip_select == 8'h00 && !ebi_fwd.valid)
    else $error("sram access forwarded");
  // low space never reaches the peripherals
  int_route_a: assert property ( // RQ1
    @(posedge clk) disable iff (!srst_n)
    a && in_int |-> !per_fwd.valid)
    else $error("internal misrouted");
  // sram word write lands in one cycle
  sram_write_a: assert property ( // RQ6
    @(posedge clk) disable iff (!srst_n)
    ce && a && sram_sel && core_req.write && core_req.size == MCDR_SZ_WORD |=>
    sram_mem[$past(widx)] == $past(core_req.wdata))
    else $error("sram write not one cycle");
  // sram read answers in one cycle
  sram_read_a: assert property ( // RQ6
    @(posedge clk) disable iff (!srst_n)
    ce && a && sram_sel && !core_req.write |=> core_rdata == sram_mem[$past(widx)])
    else $error("sram read not one cycle");
endmodule : mcdr_top
`default_nettype wire

// *** sim/mcdr_core_model.sv ***
/*
  partner model: the processor core issuing one request per cycle.
  assumes the bench calls its tasks just after a falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module mcdr_core_model
  import mcdr_pkg::*;
(
  output var mcdr_req_t core_req  // request toward the controller
);
  // idle at time zero
  initial core_req = '0;

  // present one access, held for a whole cycle
  task issue(input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
    core_req = '{valid: 1'b1, write: w, size: sz, addr: a, wdata: d};
  endtask : issue

  // released bus shows inverted leftovers, never a stale match
  task quiet();
    core_req = '{valid: 1'b0, write: 1'b0, size: core_req.size,
                 addr: ~core_req.addr, wdata: ~core_req.wdata};
  endtask : quiet
endmodule : mcdr_core_model
`default_nettype wire

// *** sim/memory_controller_decode_remap_tb_top.sv ***
/*
  self-checking bench for the decode and remap block.
  assumes strap filter shortened to 3 cycles; inputs move on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module memory_controller_decode_remap_tb_top;
  import mcdr_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;          // held low at start
  logic        int_reset = 1'b0;
  logic        ce = 1'b1;
  logic        strap = 1'b1;         // 8-bit boot first
  logic        remap_cmd = 1'b0;
  logic [7:0]  ebi_defined = 8'h84;  // banks 2 and 7 exist
  logic [31:0] ebi_rdata = 32'ha5a5_0f0f;
  logic [31:0] per_rdata = 32'h5a5a_f0f0;
  mcdr_req_t   core_req;
  mcdr_fwd_t   ebi_fwd, per_fwd;
  logic [31:0] core_rdata;
  logic [7:0]  chip_select;
  logic        core_abort, boot_is_8bit, remapped, per_icu_sel;
  int          error_cnt = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  mcdr_core_model u_core (.core_req(core_req));

  mcdr_top #(.STRAP_CYC(3)) u_dut (
    .clk(clk), .rstn(rstn), .int_reset(int_reset), .ce(ce), .boot_width_strap(strap),
    .core_req(core_req), .remap_command_bit(remap_cmd), .ebi_defined(ebi_defined),
    .core_rdata(core_rdata), .core_abort(core_abort), .ebi_fwd(ebi_fwd),
    .chip_select(chip_select), .boot_is_8bit(boot_is_8bit), .remapped(remapped),
    .ebi_rdata(ebi_rdata), .per_fwd(per_fwd), .per_icu_sel(per_icu_sel), .per_rdata(per_rdata));

  // single comparison point
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // request for one cycle; combinational outputs settle after 1 ns
  task acc(input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    u_core.issue(w, sz, a, d);
    #1;
  endtask : acc

  // drop the request; registered answers are then visible
  task idle();
    @(negedge clk);
    u_core.quiet();
    #1;
  endtask : idle

  // reset pulse of 6 cycles, then wait out sync and strap latch
  task do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
  endtask : do_reset

  // one-cycle remap write strobe
  task remap();
    @(negedge clk);
    remap_cmd = 1'b1;
    @(negedge clk);
    remap_cmd = 1'b0;
  endtask : remap

  // boot decode before remap
  task t_boot();
    chk(boot_is_8bit, 1);
    chk(remapped, 0);
    acc(0, MCDR_SZ_WORD, 32'h0, 0);
    chk(chip_select, 8'h01);
    acc(0, MCDR_SZ_WORD, 32'h0200_0000, 0);
    chk(chip_select, 8'h00);
    idle();
    chk(core_abort, 1);
  endtask : t_boot

  // internal sram after remap, mixed sizes back to back
  task t_sram();
    remap();
    chk(remapped, 1);
    acc(1, MCDR_SZ_WORD, 32'h100, 32'hdead_beef);
    chk(chip_select, 8'h00);
    acc(1, MCDR_SZ_BYTE, 32'h101, 32'h5555_5555);
    acc(0, MCDR_SZ_WORD, 32'h100, 0);
    idle();
    chk(core_rdata, 32'hdead_55ef);
    chk(core_abort, 0);
    acc(0, MCDR_SZ_WORD, 32'h003f_fffc, 0);
    chk({ebi_fwd.valid, per_fwd.valid}, 0);
  endtask : t_sram

  // external banks: defined, top edge, undefined
  task t_ext();
    acc(1, MCDR_SZ_HALF, 32'h0200_0012, 32'h0000_1234);
    chk(chip_select, 8'h04);
    chk({ebi_fwd.valid, ebi_fwd.size}, {1'b1, MCDR_SZ_HALF});
    chk(ebi_fwd.addr, 32'h0200_0012);
    chk(ebi_fwd.be, 4'hc);
    chk({ebi_fwd.write, ebi_fwd.wdata[30:0]}, {1'b1, 31'h0000_1234});
    acc(0, MCDR_SZ_WORD, 32'hffbf_fffc, 0);
    chk(chip_select, 8'h80);
    idle();
    chk(core_rdata, 32'ha5a5_0f0f);
    chk(core_abort, 0);
    acc(0, MCDR_SZ_BYTE, 32'h0300_0000, 0);
    idle();
    chk(core_abort, 1);
  endtask : t_ext

  // peripheral narrowing and interrupt unit window
  task t_per();
    acc(0, MCDR_SZ_BYTE, 32'hffc0_4003, 0);
    chk(per_fwd.addr, 32'hffc0_4000);
    chk({per_fwd.valid, per_fwd.size, per_fwd.be}, {1'b1, MCDR_SZ_WORD, 4'hf});
    chk(per_icu_sel, 0);
    acc(0, MCDR_SZ_HALF, 32'hffff_cffe, 0);
    chk(per_icu_sel, 1);
    chk(core_rdata, 32'h5a5a_f0f0);
    chk(core_abort, 0);
    acc(0, MCDR_SZ_WORD, 32'hffff_d000, 0);
    chk(per_icu_sel, 0);
    acc(1, MCDR_SZ_HALF, 32'hffc0_8002, 32'h0000_abcd);
    chk(per_fwd.wdata, 32'h0000_abcd);
    chk({per_fwd.write, per_fwd.addr[1:0]}, 3'h4);
    idle();
  endtask : t_per

  // clears: internal reset, frozen clock enable, pin reset with new strap
  task t_rst();
    @(negedge clk);
    int_reset = 1'b1;
    @(negedge clk);
    int_reset = 1'b0;
    chk(remapped, 0);
    chk(boot_is_8bit, 1);
    ce = 1'b0;
    remap();
    chk(remapped, 0);
    ce = 1'b1;
    remap();
    strap = 1'b0;
    @(negedge clk);
    rstn = 1'b0;
    #1;
    chk(remapped, 0);
    do_reset();
    chk(boot_is_8bit, 0);
    chk(remapped, 0);
  endtask : t_rst

  // verdict in one place
  task conclude();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    t_boot();
    t_sram();
    t_ext();
    t_per();
    t_rst();
    conclude();
  end

  // watchdog at 10000 cycles, far beyond the roughly fifty cycles needed
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule : memory_controller_decode_remap_tb_top
`default_nettype wire
